// ---- core/cps_pkg.sv ----
// constants, register layout and state encoding of the charger power mode sequencer
package cps_pkg;

   // clock and timing
   localparam int unsigned CPS_CLK_HZ        = 50_000_000;
   localparam int unsigned CPS_WAKE1_MS      = 500;      // first wake interval, milliseconds
   localparam int unsigned CPS_WAKE1_CYCLES  = (CPS_CLK_HZ / 1000) * CPS_WAKE1_MS;
   localparam int unsigned CPS_CNT_W         = 25;

   // serial bus target address
   localparam logic [6:0] CPS_BUS_ADDR7      = 7'h6B;
   localparam logic [7:0] CPS_BUS_ADDR8W     = 8'hD6;

   // wishbone register byte offsets
   localparam logic [7:0] CPS_OFS_CTRL       = 8'h00;
   localparam logic [7:0] CPS_OFS_STATUS     = 8'h04;
   localparam logic [7:0] CPS_OFS_ADDR       = 8'h08;

   // control register fields
   localparam int unsigned CPS_CTRL_SHIP     = 0;
   localparam int unsigned CPS_CTRL_SWREG    = 1;
   localparam int unsigned CPS_CTRL_CHGALLOW = 2;
   localparam logic [2:0]  CPS_CTRL_RESET    = 3'h4;     // charging allowed, switch off, no ship request

   // status register fields above the mode bits
   localparam int unsigned CPS_ST_FET        = 8;
   localparam int unsigned CPS_ST_VDD        = 9;
   localparam int unsigned CPS_ST_SYSIN      = 10;
   localparam int unsigned CPS_ST_CHG        = 11;
   localparam int unsigned CPS_ST_SHIPPEND   = 12;

   // synchronised comparator flag positions
   localparam int unsigned CPS_F_VIN_UV      = 0;        // input above undervoltage
   localparam int unsigned CPS_F_VIN_OV      = 1;        // input above overvoltage
   localparam int unsigned CPS_F_VIN_DPM     = 2;        // input above power-management level
   localparam int unsigned CPS_F_VIN_SLP     = 3;        // input above battery plus sleep offset
   localparam int unsigned CPS_F_BAT_UV      = 4;        // battery above undervoltage
   localparam int unsigned CPS_F_BAT_REL     = 5;        // battery above undervoltage plus hysteresis
   localparam int unsigned CPS_F_BAT_MAX     = 6;        // battery above highest selectable threshold
   localparam int unsigned CPS_F_OCP         = 7;        // discharge over-current trip
   localparam int unsigned CPS_NFLAGS        = 8;

   // operating modes, one-hot
   typedef enum logic [7:0] {
      CPS_OFF        = 8'h01,
      CPS_WAKE_CHECK = 8'h02,
      CPS_WAKE_TIMER = 8'h04,
      CPS_SHIP       = 8'h08,
      CPS_SHIP_WAKE  = 8'h10,
      CPS_ACTIVE     = 8'h20,
      CPS_LOW_POWER  = 8'h40,
      CPS_CHARGE     = 8'h80
   } cps_state_t;

endpackage

// ---- core/cps_mode_seq.sv ----
// mode sequencer of a single-cell charger with power path, wishbone register slave
//
// Overview of operation
// - four modes: charge, active battery, low power, ship
// - bus, interrupt, overcurrent only in charge/active
// - ship latches off until input or long press
// - ship request waits for input removal
// - ship request waits for button release
// - button ship exit needs battery above maximum threshold
// - host clears ship bit only with input; watchdog never
// - low power needs pin low, no input, idle
// - low power keeps rail, stops bus and clocks
// - switch regulator keeps its enable in low power
// - low power exits on pin high or input
// - overvoltage input with pin low gives active mode
// - button low in low power gives active mode
// - battery fet on outside ship, off on overcurrent; here also off in off, wake check, wake timer, ship wake
// - fet off below undervoltage, on above hysteresis
// - charge mode feeds rail from input, charges
// - input insertion wakes rail, feeds system, charges
// - battery insertion samples button, ship if high
// - battery insertion with button low runs wake timer
// - fixed seven-bit serial target address
// - registers kept while any supply stays valid
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

module cps_mode_seq
   import cps_pkg::*;
#(
   parameter int unsigned WAKE1_CYCLES = CPS_WAKE1_CYCLES
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone classic slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // analog comparator flags, asynchronous
   input  wire logic [7:0]  comp_flags_i,
   // pins and system events
   input  wire logic        push_button_n_i,
   input  wire logic        low_power_pin_n_i,
   input  wire logic        charge_enable_n_i,
   input  wire logic        charge_done_i,
   input  wire logic        serial_busy_i,
   input  wire logic        irq_pending_i,
   input  wire logic        serial_watchdog_expire_i,
   // power and mode controls
   output logic             internal_rail_o,
   output logic             system_rail_o,
   output logic             battery_discharge_fet_o,
   output logic             switch_regulator_output_o,
   output logic             charge_active_o,
   output logic             serial_enable_o,
   output logic             irq_enable_o,
   output logic             ocp_enable_o,
   output logic             clock_run_o,
   output logic [7:0]       mode_o
);

   // comparator synchroniser, two stages per flag
   logic [CPS_NFLAGS-1:0] flag_meta;
   logic [CPS_NFLAGS-1:0] flag_s;

   genvar gi;
   generate
      for (gi = 0; gi < CPS_NFLAGS; gi++) begin : g_sync
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               flag_meta[gi] <= 1'b0;
               flag_s[gi]    <= 1'b0;
            end else begin
               flag_meta[gi] <= comp_flags_i[gi];
               flag_s[gi]    <= flag_meta[gi];
            end
         end
      end
   endgenerate

   // named comparator results
   wire vin_valid  = flag_s[CPS_F_VIN_UV];
   wire vin_ovp    = flag_s[CPS_F_VIN_OV];
   wire vin_dpm    = flag_s[CPS_F_VIN_DPM];
   wire vin_slp    = flag_s[CPS_F_VIN_SLP];
   wire bat_ok     = flag_s[CPS_F_BAT_UV];
   wire bat_rel    = flag_s[CPS_F_BAT_REL];
   wire bat_max    = flag_s[CPS_F_BAT_MAX];
   wire ocp_trip   = flag_s[CPS_F_OCP];
   wire button_low = ~push_button_n_i;
   wire lp_low     = ~low_power_pin_n_i;
   // an overvoltage input is refused as a source, so entry to charge from active and staying in charge need both
   wire supply_ok  = vin_valid & ~vin_ovp;

   cps_state_t             state;
   cps_state_t             next_state;
   logic [CPS_CNT_W-1:0]   wake_cnt;
   logic [CPS_CNT_W-1:0]   next_wake_cnt;
   logic [2:0]             ctrl;
   logic                   uv_ok;
   logic                   next_uv_ok;

   wire [CPS_CNT_W-1:0] wake_limit = CPS_CNT_W'(WAKE1_CYCLES);
   wire wake_done  = (wake_cnt == wake_limit);
   wire ship_req   = ctrl[CPS_CTRL_SHIP];
   wire in_charge  = (state == CPS_CHARGE);
   wire in_active  = (state == CPS_ACTIVE);
   wire in_lp      = (state == CPS_LOW_POWER);
   wire in_ship    = (state == CPS_SHIP);
   wire bus_ok     = in_charge | in_active;
   // pending bus cycles and unsent interrupts hold off low power
   wire sys_idle   = ~cyc_i & ~ack_o & ~serial_busy_i & ~irq_pending_i;
   wire lp_enter   = lp_low & ~vin_valid & ~button_low & sys_idle;
   wire ship_go    = ship_req & ~vin_valid & ~button_low;

   // mode transitions
   always_comb begin
      next_state = state;
      case (state)
         CPS_OFF: begin
            if (vin_valid)
               next_state = CPS_CHARGE;
            else if (bat_ok)
               next_state = CPS_WAKE_CHECK;
         end
         CPS_WAKE_CHECK: begin
            if (vin_valid)
               next_state = CPS_CHARGE;
            else if (!button_low)
               next_state = CPS_SHIP;
            else
               next_state = CPS_WAKE_TIMER;
         end
         CPS_WAKE_TIMER: begin
            if (vin_valid)
               next_state = CPS_CHARGE;
            else if (!button_low)
               next_state = CPS_SHIP;
            else if (wake_done)
               next_state = CPS_ACTIVE;
         end
         CPS_SHIP: begin
            if (vin_valid)
               next_state = CPS_CHARGE;
            else if (button_low && bat_max)
               next_state = CPS_SHIP_WAKE;
         end
         CPS_SHIP_WAKE: begin
            if (vin_valid)
               next_state = CPS_CHARGE;
            else if (!button_low)
               next_state = wake_done ? CPS_ACTIVE : CPS_SHIP;
         end
         CPS_ACTIVE: begin
            if (supply_ok)
               next_state = CPS_CHARGE;
            else if (ship_go)
               next_state = CPS_SHIP;
            else if (!bat_ok && !vin_valid)
               next_state = CPS_OFF;
            else if (lp_enter)
               next_state = CPS_LOW_POWER;
         end
         CPS_LOW_POWER: begin
            // button low keeps clocks running for a long press
            if (vin_valid || !lp_low || button_low)
               next_state = CPS_ACTIVE;
         end
         CPS_CHARGE: begin
            if (!supply_ok) begin
               if (ship_go)
                  next_state = CPS_SHIP;
               else if (bat_ok || vin_valid)
                  next_state = CPS_ACTIVE;
               else
                  next_state = CPS_OFF;
            end
         end
         default: next_state = CPS_OFF;
      endcase
   end

   // wake timer runs only while the button is held during a wake attempt
   always_comb begin
      next_wake_cnt = '0;
      if ((state == CPS_WAKE_TIMER || state == CPS_SHIP_WAKE) && button_low)
         next_wake_cnt = wake_done ? wake_cnt : wake_cnt + CPS_CNT_W'(1);
   end

   // undervoltage hysteresis: trip below threshold, release only above it plus offset
   always_comb begin
      next_uv_ok = uv_ok;
      if (!bat_ok)
         next_uv_ok = 1'b0;
      else if (bat_rel)
         next_uv_ok = 1'b1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state    <= CPS_OFF;
         wake_cnt <= '0;
         uv_ok    <= 1'b0;
      end else begin
         state    <= next_state;
         wake_cnt <= next_wake_cnt;
         uv_ok    <= next_uv_ok;
      end
   end

   // wishbone decode
   wire bus_hit    = cyc_i & stb_i & ~ack_o;
   wire sel_ctrl   = (adr_i == CPS_OFS_CTRL);
   wire sel_status = (adr_i == CPS_OFS_STATUS);
   wire sel_addr   = (adr_i == CPS_OFS_ADDR);
   // writes outside charge and active modes are acknowledged and dropped
   wire wr_ctrl    = bus_hit & we_i & sel_i[0] & sel_ctrl & bus_ok;
   // the host may drop the ship request only while the input is valid
   wire ship_wr    = wr_ctrl & (dat_i[CPS_CTRL_SHIP] | vin_valid);
   // hardware consumes the request on ship entry; a host set in that cycle wins
   wire ship_clr   = (next_state == CPS_SHIP) & (state != CPS_SHIP);

   wire [31:0] status_word = {19'h0_0000, ship_req, charge_active_o, system_rail_o,
                              internal_rail_o, battery_discharge_fet_o, state};
   wire [31:0] read_word   = !bus_ok    ? 32'h0000_0000 :
                             sel_ctrl   ? {29'h0000_0000, ctrl} :
                             sel_status ? status_word :
                             sel_addr   ? {25'h000_0000, CPS_BUS_ADDR7} :
                                          32'h0000_0000;

   // control register; reset loads it, ship entry clears the ship bit, modes leave the rest alone
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CPS_CTRL_RESET;
      end else begin
         if (ship_wr)
            ctrl[CPS_CTRL_SHIP] <= dat_i[CPS_CTRL_SHIP];
         else if (ship_clr)
            ctrl[CPS_CTRL_SHIP] <= 1'b0;
         // watchdog restores the other fields but never the ship request
         if (wr_ctrl) begin
            ctrl[CPS_CTRL_SWREG]     <= dat_i[CPS_CTRL_SWREG];
            ctrl[CPS_CTRL_CHGALLOW]  <= dat_i[CPS_CTRL_CHGALLOW];
         end else if (serial_watchdog_expire_i) begin
            ctrl[CPS_CTRL_SWREG]     <= CPS_CTRL_RESET[CPS_CTRL_SWREG];
            ctrl[CPS_CTRL_CHGALLOW]  <= CPS_CTRL_RESET[CPS_CTRL_CHGALLOW];
         end
      end
   end

   // one wait-free answer per request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_hit;
         dat_o <= bus_hit ? read_word : 32'h0000_0000;
      end
   end

   // power gating per mode
   wire rail_on     = in_charge | in_active | in_lp | (state == CPS_WAKE_CHECK) | (state == CPS_WAKE_TIMER);
   wire batt_mode   = in_active | in_lp;
   // the over-current guard also runs in charge mode, so a trip opens the fet there too
   wire next_fet    = ((batt_mode & uv_ok) | in_charge) & ~ocp_trip;
   wire next_sysin  = in_charge & vin_slp & ~vin_ovp;
   wire next_chg    = in_charge & vin_dpm & ~charge_enable_n_i & ~charge_done_i
                      & ctrl[CPS_CTRL_CHGALLOW];
   wire next_swreg  = (in_charge | batt_mode) & ctrl[CPS_CTRL_SWREG];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         internal_rail_o           <= 1'b0;
         system_rail_o             <= 1'b0;
         battery_discharge_fet_o   <= 1'b0;
         switch_regulator_output_o <= 1'b0;
         charge_active_o           <= 1'b0;
         serial_enable_o           <= 1'b0;
         irq_enable_o              <= 1'b0;
         ocp_enable_o              <= 1'b0;
         clock_run_o               <= 1'b0;
         mode_o                    <= CPS_OFF;
      end else begin
         internal_rail_o           <= rail_on;
         system_rail_o             <= next_sysin;
         battery_discharge_fet_o   <= next_fet;
         switch_regulator_output_o <= next_swreg;
         charge_active_o           <= next_chg;
         serial_enable_o           <= bus_ok;
         irq_enable_o              <= bus_ok;
         ocp_enable_o              <= bus_ok;
         clock_run_o               <= ~in_lp & ~in_ship & (state != CPS_OFF);
         mode_o                    <= state;
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_ONE_MODE: assert property ($onehot(state))
      else $error("mode not one-hot");
   AST_BUS_GATE: assert property (serial_enable_o |-> $past(in_charge || in_active))
      else $error("serial enabled outside charge or active mode");
   AST_SHIP_LATCH: assert property (in_ship && !vin_valid && !button_low |=> in_ship ##1 !battery_discharge_fet_o)
      else $error("ship mode left without a wake cause");
   AST_DEFER_INPUT: assert property (in_charge && vin_valid |=> !in_ship)
      else $error("ship entered with input present");
   AST_DEFER_BUTTON: assert property (in_active && button_low |=> !in_ship)
      else $error("ship entered with button held");
   AST_SHIP_EXIT_BATT: assert property (in_ship && !bat_max |=> state != CPS_SHIP_WAKE)
      else $error("ship wake with low battery");
   AST_SHIP_BIT_WDOG: assert property (ship_req && serial_watchdog_expire_i && !wr_ctrl && !ship_clr |=> ship_req)
      else $error("watchdog cleared ship request");
   AST_LP_ENTRY: assert property ($rose(in_lp) |-> $past(lp_low && !vin_valid && !button_low && sys_idle))
      else $error("low power entered without its conditions");
   AST_LP_EXIT: assert property (in_lp && (!lp_low || button_low) |=> in_active ##1 clock_run_o)
      else $error("low power not left on pin or button");
   AST_WAKE_TIME: assert property ((state == CPS_WAKE_TIMER) ##1 in_active |-> $past(wake_cnt) == wake_limit)
      else $error("wake timer ended early");
   AST_UV_FET: assert property (batt_mode && !bat_ok && !vin_valid |=> ##1 !battery_discharge_fet_o)
      else $error("fet on below battery undervoltage");

   // battery fet: on above the band in battery modes, off on a trip
   AST_FET_OCP: assert property (ocp_trip |=> !battery_discharge_fet_o)
      else $error("fet on during over-current trip");
   AST_FET_ON: assert property (batt_mode && uv_ok && !ocp_trip |=> battery_discharge_fet_o)
      else $error("fet off in battery mode");

   // gates that follow the mode one clock later
   AST_IRQ_GATE: assert property (irq_enable_o |-> $past(bus_ok))
      else $error("interrupt enabled outside charge or active mode");
   AST_OCP_GATE: assert property (ocp_enable_o |-> $past(bus_ok))
      else $error("over-current guard outside charge or active mode");
   AST_READ_ZERO: assert property (ack_o && !$past(bus_ok) |-> dat_o == 32'h0000_0000)
      else $error("read data outside charge or active mode");
   AST_LP_PIN_IGNORED: assert property (in_charge && supply_ok |=> in_charge)
      else $error("charge mode left with a usable supply");
   AST_CHG_GATE: assert property (charge_active_o |-> $past(in_charge && vin_dpm && !charge_enable_n_i))
      else $error("charging outside charge mode");
   AST_CHG_DONE: assert property (charge_done_i |=> !charge_active_o)
      else $error("charging after termination");
   AST_SYS_FEED: assert property (system_rail_o |-> $past(in_charge && vin_slp && !vin_ovp))
      else $error("system rail fed from an unusable input");
   AST_CHARGE_SRC: assert property (in_charge |-> $past(vin_valid))
      else $error("charge mode without input");

   // ship mode keeps every rail down; a short press falls back into it
   wire short_press = (state == CPS_SHIP_WAKE) & ~button_low & ~wake_done;
   AST_SHIP_DARK: assert property (in_ship |=> !internal_rail_o && !system_rail_o)
      else $error("rail on in ship mode");
   AST_SHORT_PRESS: assert property (short_press && !vin_valid |=> in_ship)
      else $error("short press left ship mode");
   AST_INSERT_RAIL: assert property (state == CPS_WAKE_CHECK |=> internal_rail_o)
      else $error("rail not raised on battery insertion");
   AST_INSERT_SHIP: assert property (state == CPS_WAKE_CHECK && !vin_valid && !button_low |=> in_ship)
      else $error("battery insertion without press missed ship mode");

   // low power keeps the rail and the switch state, stops bus and clocks
   AST_LP_OUTPUTS: assert property (in_lp |=> internal_rail_o && !serial_enable_o && !clock_run_o)
      else $error("low power outputs wrong");
   AST_LP_SWREG: assert property (in_lp |=> switch_regulator_output_o == $past(ctrl[CPS_CTRL_SWREG]))
      else $error("switch output changed in low power");
   AST_OVP_ACTIVE: assert property (in_lp && vin_valid |=> in_active)
      else $error("low power kept with input present");
   AST_OVP_STAY: assert property (in_active && vin_valid && vin_ovp |=> in_active)
      else $error("overvoltage input left active mode");

endmodule // cps_mode_seq

// ---- test/cps_host_model.sv ----
// host processor model: wishbone master and push button
`timescale 1ns/1ps
module cps_host_model (
   // clock
   input  wire logic        clk_i,
   // wishbone master side
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o,
   input  wire logic [31:0] dat_i,
   input  wire logic        ack_i,
   // push button, active low
   output logic             push_button_n_o
);
   // idle bus and button released at time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0000_0000;
      push_button_n_o = 1'b1;
   end

   // one classic cycle, request held until ack is sampled high; only the bench timeout ends a hang
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= s;
      dat_o <= d;
      do begin
         @(posedge clk_i);
      end while (ack_i !== 1'b1);
      q = dat_i;
      // released address and data flip so a stale value never passes for a live one
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      sel_o <= 4'h0;
      adr_o <= ~a;
      dat_o <= ~d;
   endtask

   // button level changes just after an edge; the bench holds it low through a power cycle
   task automatic button(input logic lvl);
      @(posedge clk_i);
      push_button_n_o <= lvl;
   endtask
endmodule // cps_host_model

// ---- test/cps_mode_seq_test.sv ----
// self-checking bench of the charger power mode sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module cps_mode_seq_test;
   import cps_pkg::*;
   localparam int unsigned WAKE  = 8;
   localparam int unsigned LIMIT = 20000;
   logic        clk_i, rst_i, cyc, stb, we, ack, pb_n, lp_n, ce_n, busy, wdog, done, irq;
   logic        irail, srail, fet, swreg, chg, ser_en, irq_en, ocp_en, crun;
   logic [7:0]  adr, flags, mode;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   int          failures, n_tests, cycles;

   cps_mode_seq #(.WAKE1_CYCLES(WAKE)) cps_mode_seq_i (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .comp_flags_i(flags), .push_button_n_i(pb_n),
      .low_power_pin_n_i(lp_n), .charge_enable_n_i(ce_n), .charge_done_i(done), .serial_busy_i(busy),
      .irq_pending_i(irq), .serial_watchdog_expire_i(wdog), .internal_rail_o(irail),
      .system_rail_o(srail), .battery_discharge_fet_o(fet), .switch_regulator_output_o(swreg),
      .charge_active_o(chg), .serial_enable_o(ser_en), .irq_enable_o(irq_en), .ocp_enable_o(ocp_en),
      .clock_run_o(crun), .mode_o(mode));
   cps_host_model cps_host_model_i (
      .clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat),
      .dat_i(rdat), .ack_i(ack), .push_button_n_o(pb_n));

   // 50 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic end_of_test();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // hang guard, generous against a run of a few hundred cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         failures++;
         end_of_test();
      end
   end

   // bounded wait for a mode, then two edges so the outputs follow it
   task automatic wait_mode(input logic [7:0] m);
      int n;
      n = 0;
      while (mode !== m && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      `CHK("mode", m, mode)
      repeat (2) @(posedge clk_i);
   endtask
   task automatic stay(input logic [7:0] m);
      repeat (12) @(posedge clk_i);
      `CHK("mode held", m, mode)
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      cps_host_model_i.xfer(1'b0, a, 4'hf, 32'h0000_0000, q);
      `CHK("read data", e, q)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cps_host_model_i.xfer(1'b1, a, 4'h1, d, q);
   endtask
   task automatic set_flags(input logic [7:0] f);
      @(posedge clk_i);
      flags <= f;
   endtask
   // long press out of ship mode with the battery above the top threshold
   task automatic wake();
      cps_host_model_i.button(1'b0);
      wait_mode(8'h10);
      repeat (WAKE + 4) @(posedge clk_i);
      cps_host_model_i.button(1'b1);
      wait_mode(8'h20);
   endtask

   task automatic t_battery_ship();
      rd(CPS_OFS_ADDR, 32'h0000_0000);
      set_flags(8'h30);
      wait_mode(8'h08);
      `CHK("internal rail", 1'b0, irail)
      `CHK("fet", 1'b0, fet)
      rd(CPS_OFS_ADDR, 32'h0000_0000);
      cps_host_model_i.button(1'b0);
      stay(8'h08);
      cps_host_model_i.button(1'b1);
      set_flags(8'h70);
      // a short press returns to ship mode
      cps_host_model_i.button(1'b0);
      wait_mode(8'h10);
      cps_host_model_i.button(1'b1);
      wait_mode(8'h08);
      wake();
      `CHK("fet", 1'b1, fet)
      `CHK("bus enable", 1'b1, ser_en)
      `CHK("irq enable", 1'b1, irq_en)
      `CHK("ocp enable", 1'b1, ocp_en)
   endtask

   task automatic t_regs_fet();
      rd(CPS_OFS_ADDR, 32'h0000_006B);
      rd(8'h0C, 32'h0000_0000);
      wr(CPS_OFS_CTRL, 32'h0000_0006);
      rd(CPS_OFS_CTRL, 32'h0000_0006);
      `CHK("switch out", 1'b1, swreg)
      set_flags(8'hF0);
      repeat (6) @(posedge clk_i);
      `CHK("fet on trip", 1'b0, fet)
      // byte lane 0 low: the write is dropped
      cps_host_model_i.xfer(1'b1, CPS_OFS_CTRL, 4'he, 32'h0000_0000, q);
      rd(CPS_OFS_CTRL, 32'h0000_0006);
      set_flags(8'h00);
      wait_mode(8'h01);
      `CHK("fet low battery", 1'b0, fet)
      // back inside the hysteresis band the fet stays off after a wake
      set_flags(8'h50);
      wait_mode(8'h08);
      wake();
      `CHK("fet in band", 1'b0, fet)
      set_flags(8'h70);
      repeat (6) @(posedge clk_i);
      `CHK("fet released", 1'b1, fet)
   endtask

   // busy bus holds off low power; button and pin move it back out
   task automatic t_low_power();
      @(posedge clk_i) busy <= 1'b1;
      @(posedge clk_i) lp_n <= 1'b0;
      stay(8'h20);
      // an unsent interrupt holds off low power as well
      @(posedge clk_i) begin
         busy <= 1'b0;
         irq  <= 1'b1;
      end
      stay(8'h20);
      @(posedge clk_i) irq <= 1'b0;
      wait_mode(8'h40);
      `CHK("bus enable", 1'b0, ser_en)
      `CHK("clock run", 1'b0, crun)
      `CHK("internal rail", 1'b1, irail)
      `CHK("switch out", 1'b1, swreg)
      `CHK("irq enable", 1'b0, irq_en)
      `CHK("ocp enable", 1'b0, ocp_en)
      cps_host_model_i.button(1'b0);
      wait_mode(8'h20);
      `CHK("clock run", 1'b1, crun)
      rd(CPS_OFS_ADDR, 32'h0000_006B);
      cps_host_model_i.button(1'b1);
      wait_mode(8'h40);
      @(posedge clk_i) lp_n <= 1'b1;
      wait_mode(8'h20);
      @(posedge clk_i) lp_n <= 1'b0;
      wait_mode(8'h40);
      set_flags(8'h73);
      wait_mode(8'h20);
      stay(8'h20);
      `CHK("system rail", 1'b0, srail)
      @(posedge clk_i) lp_n <= 1'b1;
   endtask

   // charge mode, then ship requests cleared, deferred and surviving the watchdog
   task automatic t_charge_ship();
      set_flags(8'h7D);
      wait_mode(8'h80);
      `CHK("system rail", 1'b1, srail)
      `CHK("charging", 1'b1, chg)
      @(posedge clk_i) ce_n <= 1'b1;
      repeat (6) @(posedge clk_i);
      `CHK("charging", 1'b0, chg)
      @(posedge clk_i) ce_n <= 1'b0;
      @(posedge clk_i) done <= 1'b1;
      repeat (6) @(posedge clk_i);
      `CHK("charging done", 1'b0, chg)
      @(posedge clk_i) done <= 1'b0;
      repeat (6) @(posedge clk_i);
      `CHK("charging", 1'b1, chg)
      wr(CPS_OFS_CTRL, 32'h0000_0007);
      stay(8'h80);
      wr(CPS_OFS_CTRL, 32'h0000_0006);
      set_flags(8'h70);
      stay(8'h20);
      set_flags(8'h7D);
      wait_mode(8'h80);
      wr(CPS_OFS_CTRL, 32'h0000_0007);
      @(posedge clk_i) wdog <= 1'b1;
      @(posedge clk_i) wdog <= 1'b0;
      rd(CPS_OFS_CTRL, 32'h0000_0005);
      rd(CPS_OFS_STATUS, 32'h0000_1F80);
      set_flags(8'h70);
      wait_mode(8'h08);
      wake();
      cps_host_model_i.button(1'b0);
      wr(CPS_OFS_CTRL, 32'h0000_0001);
      stay(8'h20);
      cps_host_model_i.button(1'b1);
      wait_mode(8'h08);
   endtask

   // second reset, battery inserted with the button held through the wake timer
   task automatic t_wake_timer();
      @(posedge clk_i) rst_i <= 1'b1;
      flags <= 8'h00;
      cps_host_model_i.button(1'b0);
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      `CHK("mode after reset", 8'h01, mode)
      set_flags(8'h30);
      wait_mode(8'h04);
      `CHK("internal rail", 1'b1, irail)
      repeat (WAKE - 4) @(posedge clk_i);
      `CHK("mode timing", 8'h04, mode)
      wait_mode(8'h20);
      cps_host_model_i.button(1'b1);
   endtask

   // main sequence
   initial begin
      failures = 0;
      n_tests = 0;
      cycles = 0;
      rst_i = 1'b1;
      flags = 8'h00;
      lp_n = 1'b1;
      ce_n = 1'b0;
      busy = 1'b0;
      wdog = 1'b0;
      done = 1'b0;
      irq = 1'b0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      `CHK("mode after reset", 8'h01, mode)
      `CHK("clock run", 1'b0, crun)
      t_battery_ship();
      t_regs_fet();
      t_low_power();
      t_charge_ship();
      t_wake_timer();
      end_of_test();
   end
endmodule // cps_mode_seq_test
